// ---- hw/mgc_pkg.sv ----
package mgc_pkg;
  // register map: one word at offset zero
  localparam logic [15:0] MGC_ADDR_CONTROL   = 16'h0000;
  localparam int          MGC_DATA_W         = 32;
  localparam int          MGC_ADDR_W         = 16;
  // field positions
  localparam int          MGC_BIT_PORT_RST   = 0;
  localparam int          MGC_BIT_PHY_RST    = 1;
  localparam int          MGC_BIT_PHY_PWR    = 2;
  localparam int          MGC_BIT_HW_MDIO    = 3;
  localparam int          MGC_BIT_FW_MDIO    = 4;
  localparam int          MGC_BIT_INIT_DONE  = 5;
  localparam int          MGC_BIT_RD_BLOCKED = 6;
  localparam int          MGC_BIT_WAKE_EN    = 7;
  localparam int          MGC_BIT_RST_WARN   = 10;
  localparam int          MGC_BIT_RST_OK     = 11;
  // reset values
  localparam logic        MGC_RST_PHY_RST    = 1'b1;
  localparam logic        MGC_RST_PHY_PWR    = 1'b1;
  localparam logic        MGC_RST_CLEAR      = 1'b0;
  localparam logic [31:0] MGC_ZERO_WORD      = 32'h0000_0000;
endpackage

// ---- hw/mgc_arb_if.sv ----
`timescale 1ns/1ns
// firmware side of the mdio arbitration, between the register bank and the arbiter
interface mgc_arb_if;
  logic fw_request;   // firmware asks for mdio
  logic fw_release;   // firmware gives mdio back
  logic fw_granted;   // firmware semaphore flag as held by the arbiter
  modport bank (output fw_request, output fw_release, input fw_granted);
  modport arb  (input fw_request, input fw_release, output fw_granted);
endinterface

// ---- hw/mgc_mdio_arb.sv ----
`timescale 1ns/1ns
module mgc_mdio_arb
  import mgc_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic software_semaphore_flag,
  input  wire logic hw_mdio_request,
  mgc_arb_if.arb    arb
);
  logic pending_reg;
  logic pending_next;
  logic granted_reg;
  logic granted_next;

  // a request waits until software has let go and hardware is off the mdio bus
  always_comb begin
    pending_next = pending_reg;
    granted_next = granted_reg;
    if (arb.fw_request && !granted_reg) begin
      pending_next = 1'b1;
    end
    if (pending_next && !software_semaphore_flag && !hw_mdio_request) begin
      granted_next = 1'b1;
      pending_next = 1'b0;
    end
    // release beats a pending request so a write of zero always withdraws it
    if (arb.fw_release) begin
      granted_next = 1'b0;
      pending_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pending_reg <= MGC_RST_CLEAR;
      granted_reg <= MGC_RST_CLEAR;
    end else begin
      pending_reg <= pending_next;
      granted_reg <= granted_next;
    end
  end

  assign arb.fw_granted = granted_reg;
endmodule

// ---- hw/mgc_control.sv ----
`timescale 1ns/1ns
module mgc_control
  import mgc_pkg::*;
(
  input  wire logic                                clk,
  input  wire logic                                reset,
  input  wire logic                                reg_write,
  input  wire logic                                reg_read,
  input  wire logic [mgc_pkg::MGC_ADDR_W-1:0]      reg_addr,
  input  wire logic [mgc_pkg::MGC_DATA_W-1:0]      reg_wdata,
  output logic      [mgc_pkg::MGC_DATA_W-1:0]      reg_rdata,
  input  wire logic                                phy_side_reset,
  input  wire logic                                phy_powered,
  input  wire logic                                hw_mdio_request,
  input  wire logic                                software_semaphore_flag,
  output logic                                     firmware_semaphore_flag,
  input  wire logic                                lan_init_done,
  input  wire logic                                completion_error,
  input  wire logic                                link_status_change,
  output logic                                     wake_on_link_change,
  input  wire logic                                spi_pending,
  output logic                                     spi_start_hold,
  input  wire logic                                engine_reset,
  output logic                                     mgmt_port_reset
);
  import mgc_pkg::*;

  mgc_arb_if arb_bus ();

  logic                  hit;
  logic                  wr_hit;
  logic                  port_rst_reg;
  logic                  port_rst_next;
  logic                  phy_rst_seen_reg;
  logic                  phy_rst_seen_next;
  logic                  phy_pwr_reg;
  logic                  phy_pwr_next;
  logic                  hw_mdio_reg;
  logic                  hw_mdio_next;
  logic                  init_done_reg;
  logic                  init_done_next;
  logic                  rd_blocked_reg;
  logic                  rd_blocked_next;
  logic                  wake_en_reg;
  logic                  wake_en_next;
  logic                  wake_reg;
  logic                  wake_next;
  logic                  warn_reg;
  logic                  warn_next;
  logic                  ok_reg;
  logic                  ok_next;
  logic [MGC_DATA_W-1:0] rdata_reg;
  logic [MGC_DATA_W-1:0] rdata_next;

  assign hit    = (reg_addr == MGC_ADDR_CONTROL);
  assign wr_hit = reg_write && hit; // no byte lanes: every write is a whole word

  // firmware semaphore requests go through the mdio arbiter
  assign arb_bus.fw_request = wr_hit && reg_wdata[MGC_BIT_FW_MDIO];
  assign arb_bus.fw_release = wr_hit && !reg_wdata[MGC_BIT_FW_MDIO];

  mgc_mdio_arb u_arb (
    .clk                     (clk),
    .reset                   (reset),
    .software_semaphore_flag (software_semaphore_flag),
    .hw_mdio_request         (hw_mdio_request),
    .arb                     (arb_bus.arb)
  );

  // port reset: a one-cycle pulse that clears itself, so firmware never has to
  always_comb begin
    port_rst_next = wr_hit && reg_wdata[MGC_BIT_PORT_RST];
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      port_rst_reg <= MGC_RST_CLEAR;
    end else begin
      port_rst_reg <= port_rst_next;
    end
  end

  // phy-reset-seen flag; a phy reset in the clearing cycle still wins
  always_comb begin
    phy_rst_seen_next = phy_rst_seen_reg;
    if (wr_hit && !reg_wdata[MGC_BIT_PHY_RST]) begin
      phy_rst_seen_next = 1'b0;
    end
    if (phy_side_reset) begin
      phy_rst_seen_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phy_rst_seen_reg <= MGC_RST_PHY_RST;
    end else begin
      phy_rst_seen_reg <= phy_rst_seen_next;
    end
  end

  // host-side mirrors, one stage late; power means little before a phy reset
  always_comb begin
    phy_pwr_next = phy_powered;
    hw_mdio_next = hw_mdio_request;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      phy_pwr_reg <= MGC_RST_PHY_PWR;
      hw_mdio_reg <= MGC_RST_CLEAR;
    end else begin
      phy_pwr_reg <= phy_pwr_next;
      hw_mdio_reg <= hw_mdio_next;
    end
  end

  // init-done event flag; software clears it, a new completion beats the clear
  always_comb begin
    init_done_next = init_done_reg;
    if (wr_hit && !reg_wdata[MGC_BIT_INIT_DONE]) begin
      init_done_next = 1'b0;
    end
    if (lan_init_done) begin
      init_done_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      init_done_reg <= MGC_RST_CLEAR;
    end else begin
      init_done_reg <= init_done_next;
    end
  end

  // only the port reset clears it; a late error in that cycle still sticks
  always_comb begin
    rd_blocked_next = rd_blocked_reg && !port_rst_reg;
    if (completion_error) begin
      rd_blocked_next = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rd_blocked_reg <= MGC_RST_CLEAR;
    end else begin
      rd_blocked_reg <= rd_blocked_next;
    end
  end

  // wake enable and the registered one-cycle wake pulse
  always_comb begin
    wake_en_next = wr_hit ? reg_wdata[MGC_BIT_WAKE_EN] : wake_en_reg;
    wake_next    = wake_en_reg && link_status_change;
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_en_reg <= MGC_RST_CLEAR;
      wake_reg    <= MGC_RST_CLEAR;
    end else begin
      wake_en_reg <= wake_en_next;
      wake_reg    <= wake_next;
    end
  end

  // engine-reset handshake; engine reset overrides a write in the same cycle
  always_comb begin
    warn_next = wr_hit ? reg_wdata[MGC_BIT_RST_WARN] : warn_reg;
    // clear-to-go waits for the flash to go idle and holds while the warning stays set
    ok_next = warn_reg && (ok_reg || !spi_pending);
    if (engine_reset) begin
      warn_next = 1'b0;
      ok_next   = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      warn_reg <= MGC_RST_CLEAR;
      ok_reg   <= MGC_RST_CLEAR;
    end else begin
      warn_reg <= warn_next;
      ok_reg   <= ok_next;
    end
  end

  // read data is captured only on a decoded read, so other addresses leave it be
  always_comb begin
    rdata_next                     = MGC_ZERO_WORD;
    rdata_next[MGC_BIT_PORT_RST]   = port_rst_reg;
    rdata_next[MGC_BIT_PHY_RST]    = phy_rst_seen_reg;
    rdata_next[MGC_BIT_PHY_PWR]    = phy_pwr_reg;
    rdata_next[MGC_BIT_HW_MDIO]    = hw_mdio_reg;
    rdata_next[MGC_BIT_FW_MDIO]    = arb_bus.fw_granted;
    rdata_next[MGC_BIT_INIT_DONE]  = init_done_reg;
    rdata_next[MGC_BIT_RD_BLOCKED] = rd_blocked_reg;
    rdata_next[MGC_BIT_WAKE_EN]    = wake_en_reg;
    rdata_next[MGC_BIT_RST_WARN]   = warn_reg;
    rdata_next[MGC_BIT_RST_OK]     = ok_reg;
    if (!(reg_read && hit)) begin
      rdata_next = rdata_reg;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata_reg <= MGC_ZERO_WORD;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // warning alone halts new flash starts; pending ones finish before ok rises
  assign spi_start_hold          = warn_reg;
  assign mgmt_port_reset         = port_rst_reg;
  assign wake_on_link_change     = wake_reg;
  assign firmware_semaphore_flag = arb_bus.fw_granted;
  assign reg_rdata               = rdata_reg;
endmodule

// ---- verif/mgc_control_monitor.sv ----
`timescale 1ns/1ns
module mgc_control_monitor
  import mgc_pkg::*;
(
  input wire logic                            clk,
  input wire logic                            reset,
  input wire logic                            reg_write,
  input wire logic                            reg_read,
  input wire logic [mgc_pkg::MGC_ADDR_W-1:0]  reg_addr,
  input wire logic [mgc_pkg::MGC_DATA_W-1:0]  reg_wdata,
  input wire logic [mgc_pkg::MGC_DATA_W-1:0]  reg_rdata,
  input wire logic                            software_semaphore_flag,
  input wire logic                            hw_mdio_request,
  input wire logic                            firmware_semaphore_flag,
  input wire logic                            link_status_change,
  input wire logic                            wake_on_link_change,
  input wire logic                            spi_start_hold,
  input wire logic                            engine_reset,
  input wire logic                            mgmt_port_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // a write that lands on the one decoded word
  sequence s_wr;
    reg_write && reg_addr == MGC_ADDR_CONTROL;
  endsequence
  // a read of any word that is not decoded
  sequence s_rd_miss;
    reg_read && reg_addr != MGC_ADDR_CONTROL;
  endsequence
  a_port_rst_pulse: assert property (s_wr ##0 reg_wdata[0] |=> mgmt_port_reset)
    else $error("port reset pulse missing");
  a_port_rst_cause: assert property (
    mgmt_port_reset |-> $past(reg_write && reg_wdata[0]))
    else $error("port reset without a write");
  a_wake_cause: assert property (wake_on_link_change |-> $past(link_status_change))
    else $error("wake without link change");
  a_hold_set: assert property (
    s_wr ##0 reg_wdata[10] && !engine_reset |=> spi_start_hold)
    else $error("flash hold not raised");
  a_hold_steady: assert property (
    !$stable(spi_start_hold) |-> $past(reg_write || engine_reset))
    else $error("flash hold moved alone");
  a_engine_clear: assert property (engine_reset |=> !spi_start_hold)
    else $error("flash hold kept past engine reset");
  a_grant_gate: assert property ($rose(firmware_semaphore_flag)
    |-> $past(!software_semaphore_flag && !hw_mdio_request))
    else $error("grant while mdio busy");
  a_reserved_zero: assert property (
    reg_rdata[31:12] == 20'h0_0000 && reg_rdata[9:8] == 2'h0)
    else $error("reserved bits read nonzero");
  a_unmapped_hold: assert property (s_rd_miss |=> $stable(reg_rdata))
    else $error("unmapped read changed data");
endmodule
bind mgc_control mgc_control_monitor u_mon (.*);

// ---- verif/test_mgc_control.sv ----
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
`define PUL(s) begin @(posedge clk); s <= 1'b1; @(posedge clk); s <= 1'b0; end
module test_mgc_control;
  import mgc_pkg::*;
  logic clk = 0, reset = 1, reg_write = 0, reg_read = 0;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0000_0000, reg_rdata, v, w;
  logic phy_side_reset = 0, phy_powered = 1, hw_mdio_request = 0, software_semaphore_flag = 0;
  logic lan_init_done = 0, completion_error = 0, link_status_change = 0, spi_pending = 0;
  logic engine_reset = 0, firmware_semaphore_flag, wake_on_link_change, spi_start_hold;
  logic mgmt_port_reset;
  int miscompares = 0, num_checks = 0;
  mgc_control DUT (.clk(clk), .reset(reset), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .phy_side_reset(phy_side_reset), .phy_powered(phy_powered),
    .hw_mdio_request(hw_mdio_request), .software_semaphore_flag(software_semaphore_flag),
    .firmware_semaphore_flag(firmware_semaphore_flag), .lan_init_done(lan_init_done),
    .completion_error(completion_error), .link_status_change(link_status_change),
    .wake_on_link_change(wake_on_link_change), .spi_pending(spi_pending),
    .spi_start_hold(spi_start_hold), .engine_reset(engine_reset),
    .mgmt_port_reset(mgmt_port_reset));
  // 100 MHz clock
  always #5 clk = ~clk;
  // one whole word per write, never a partial lane; strobe drops on the taking edge
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
    reg_addr <= 16'h0000;
  endtask
  // data is captured on the taking edge and looked at one edge later, settled
  task automatic rd(input logic [15:0] a);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    reg_addr <= 16'h0000;
    @(posedge clk);
    v = reg_rdata;
  endtask
  task automatic t_phy;
    rd(MGC_ADDR_CONTROL);
    `CHK("reset word", 32'h0000_0006, v)
    wr(MGC_ADDR_CONTROL, 32'h0000_0000);
    rd(MGC_ADDR_CONTROL);
    `CHK("phy seen clr", 1'b0, v[1])
    `PUL(phy_side_reset)
    rd(MGC_ADDR_CONTROL);
    `CHK("phy seen set", 1'b1, v[1])
    // phy reset still high on the clearing edge: the set must win
    phy_side_reset <= 1'b1;
    wr(MGC_ADDR_CONTROL, 32'h0000_0000);
    phy_side_reset <= 1'b0;
    rd(MGC_ADDR_CONTROL);
    `CHK("phy set wins", 1'b1, v[1])
    // power mirror only looked at once a phy reset has been seen
    phy_powered <= 1'b0;
    hw_mdio_request <= 1'b1;
    rd(MGC_ADDR_CONTROL);
    `CHK("mirrors", 2'b10, v[3:2])
  endtask
  task automatic t_sem;
    // hardware on mdio holds the request back
    software_semaphore_flag <= 1'b1;
    wr(MGC_ADDR_CONTROL, 32'h0000_0010);
    software_semaphore_flag <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("grant blocked hw", 1'b0, firmware_semaphore_flag)
    hw_mdio_request <= 1'b0;
    repeat (3) @(posedge clk);
    `CHK("grant", 1'b1, firmware_semaphore_flag)
    rd(MGC_ADDR_CONTROL);
    `CHK("fw copy", 1'b1, v[4])
    wr(MGC_ADDR_CONTROL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    `CHK("release", 1'b0, firmware_semaphore_flag)
    // software holding its flag blocks the grant on its own
    software_semaphore_flag <= 1'b1;
    wr(MGC_ADDR_CONTROL, 32'h0000_0010);
    repeat (3) @(posedge clk);
    `CHK("grant blocked sw", 1'b0, firmware_semaphore_flag)
    software_semaphore_flag <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK("grant after sw", 1'b1, firmware_semaphore_flag)
    wr(MGC_ADDR_CONTROL, 32'h0000_0000);
    repeat (2) @(posedge clk);
    `CHK("release again", 1'b0, firmware_semaphore_flag)
  endtask
  task automatic t_events;
    `PUL(lan_init_done)
    `PUL(completion_error)
    rd(MGC_ADDR_CONTROL);
    `CHK("init blocked", 2'b11, v[6:5])
    wr(MGC_ADDR_CONTROL, 32'h0000_0000);
    rd(MGC_ADDR_CONTROL);
    `CHK("sw clears", 2'b10, v[6:5])
    // a completion on the clearing edge must survive the clear
    lan_init_done <= 1'b1;
    wr(MGC_ADDR_CONTROL, 32'h0000_0000);
    lan_init_done <= 1'b0;
    rd(MGC_ADDR_CONTROL);
    `CHK("init set wins", 1'b1, v[5])
    // recovery only: nothing outstanding to transmit, no bus mastering here
    wr(MGC_ADDR_CONTROL, 32'h0000_0001);
    @(posedge clk);
    `CHK("port pulse", 1'b1, mgmt_port_reset)
    @(posedge clk);
    `CHK("pulse ends", 1'b0, mgmt_port_reset)
    rd(MGC_ADDR_CONTROL);
    `CHK("port cleared", 5'b0_0000, {v[6], v[5], v[3:2], v[0]})
  endtask
  task automatic t_wake;
    `PUL(link_status_change)
    @(posedge clk);
    `CHK("wake off", 1'b0, wake_on_link_change)
    wr(MGC_ADDR_CONTROL, 32'h0000_0080);
    `PUL(link_status_change)
    @(posedge clk);
    `CHK("wake on", 1'b1, wake_on_link_change)
    @(posedge clk);
    `CHK("wake one cycle", 1'b0, wake_on_link_change)
  endtask
  task automatic t_flash;
    spi_pending <= 1'b1;
    wr(MGC_ADDR_CONTROL, 32'h0000_0400);
    @(posedge clk);
    `CHK("hold", 1'b1, spi_start_hold)
    rd(MGC_ADDR_CONTROL);
    `CHK("ok busy", 1'b0, v[11])
    spi_pending <= 1'b0;
    rd(MGC_ADDR_CONTROL);
    `CHK("ok idle", 1'b1, v[11])
    // once given, clear-to-go holds while the warning stays set, here until the engine reset
    spi_pending <= 1'b1;
    rd(MGC_ADDR_CONTROL);
    `CHK("ok sticks", 2'b11, v[11:10])
    spi_pending <= 1'b0;
    `PUL(engine_reset)
    @(posedge clk);
    `CHK("hold released", 1'b0, spi_start_hold)
    rd(MGC_ADDR_CONTROL);
    `CHK("engine clr", 2'b00, v[11:10])
  endtask
  task automatic t_reserved;
    rd(MGC_ADDR_CONTROL);
    w = v;
    wr(16'h0004, 32'hFFFF_FFFF);
    rd(16'h0004);
    `CHK("unmapped read", w, v)
    rd(MGC_ADDR_CONTROL);
    `CHK("unmapped write", w, v)
    // reserved and read-only bits written high must all read back zero
    wr(MGC_ADDR_CONTROL, 32'hFFFF_FB6C);
    rd(MGC_ADDR_CONTROL);
    `CHK("reserved", 32'h0000_0000, v)
  endtask
  task automatic results;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // watchdog: the full sequence needs about 120 cycles, this allows ten thousand
  initial begin
    #100000;
    miscompares++;
    results;
  end
  initial begin
    repeat (5) @(posedge clk); reset <= 1'b0;
    t_phy; t_sem; t_events; t_wake; t_flash; t_reserved; results;
  end
endmodule
